// >>> hw/msal_pkg.sv
// Purpose: shared constants and carrier types for the multisite all-call lockout block
// Assumes: 10 MHz system clock
// Notes:   site codes are 3-bit label plus 4-bit field
package msal_pkg;

  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned LOCKOUT_TIME_S = 18;
  // longest time, whole seconds times rate needs no rounding
  localparam logic [31:0] LOCKOUT_CYCLES = 32'(LOCKOUT_TIME_S * CLK_HZ);

  localparam int unsigned II_COUNT    = 16;
  localparam int unsigned SI_COUNT    = 63;
  localparam int unsigned TIMER_COUNT = II_COUNT + SI_COUNT;
  localparam int unsigned IDX_W       = 7;
  localparam int unsigned STAMP_W     = 32;

  localparam logic [2:0]       LABEL_II     = 3'h0;
  localparam logic [2:0]       LABEL_SI_MAX = 3'h4;
  localparam logic [IDX_W-1:0] SI_BASE_IDX  = 7'h0f;

  typedef struct packed {
    logic [2:0] label;
    logic [3:0] field;
  } msal_site_code_t;

  typedef struct packed {
    logic             ok;
    logic             is_si;
    logic [IDX_W-1:0] idx;
    logic [6:0]       parity_code;
  } msal_decode_t;

  typedef struct packed {
    logic             answer;
    logic             is_si;
    logic [6:0]       parity_code;
  } msal_reply_t;

  typedef struct packed {
    logic               valid;
    logic [STAMP_W-1:0] stamp;
  } msal_entry_t;

endpackage

// >>> hw/msal_timer_mem.sv
// Purpose: lockout timer store, one entry per site code, two registered read ports
// Assumes: single clock, synchronous active-high reset
// Notes:   only the valid bits are reset; stamps are meaningless while invalid
`timescale 1ns/1ns
module msal_timer_mem (
  input  wire logic                           clk_in,
  input  wire logic                           srst_in,
  input  wire logic                           wr_en_in,
  input  wire logic [msal_pkg::IDX_W-1:0]     wr_addr_in,
  input  wire msal_pkg::msal_entry_t          wr_data_in,
  input  wire logic [msal_pkg::IDX_W-1:0]     rd_a_addr_in,
  output msal_pkg::msal_entry_t               rd_a_data_out,
  input  wire logic [msal_pkg::IDX_W-1:0]     rd_b_addr_in,
  output msal_pkg::msal_entry_t               rd_b_data_out
);

  logic [msal_pkg::TIMER_COUNT-1:0] valid_q;
  logic [msal_pkg::STAMP_W-1:0]     stamp_q [msal_pkg::TIMER_COUNT];

  // read returns the value held before a same-cycle write; caller forwards
  always_ff @(posedge clk_in) begin
    rd_a_data_out <= {valid_q[rd_a_addr_in], stamp_q[rd_a_addr_in]};
    rd_b_data_out <= {valid_q[rd_b_addr_in], stamp_q[rd_b_addr_in]};
  end

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      stamp_q[wr_addr_in] <= wr_data_in.stamp;
    end
  end

  genvar g;
  generate
    for (g = 0; g < msal_pkg::TIMER_COUNT; g++) begin : g_valid
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          valid_q[g] <= 1'b0;
        end else if (wr_en_in && wr_addr_in == 7'(g)) begin
          valid_q[g] <= wr_data_in.valid;
        end
      end
    end
  endgenerate

endmodule // msal_timer_mem

// >>> hw/msal_top.sv
// Purpose: transponder all-call answer decision with per-site-code lockout timers
// Assumes: request strobes come from logic on clk_in; 10 MHz clock
// Notes:   answer appears two cycles after the all-call strobe
//          stamps wrap after about seven minutes; the sweep keeps that harmless
//          invalid site codes are refused and never touch a timer
//          one write port: a lockout command beats an expiry clear
`timescale 1ns/1ns
module msal_top #(
  parameter logic [31:0] LOCKOUT_CYCLES = msal_pkg::LOCKOUT_CYCLES
) (
  input  wire logic                      clk_in,
  input  wire logic                      srst_in,
  input  wire logic                      si_capable_in,
  input  wire logic                      allcall_valid_in,
  input  wire msal_pkg::msal_site_code_t allcall_code_in,
  input  wire logic                      lock_cmd_valid_in,
  input  wire msal_pkg::msal_site_code_t lock_code_in,
  output logic                           reply_valid_out,
  output msal_pkg::msal_reply_t          reply_out
);

  // map a received site code onto a timer index and a parity code
  function automatic msal_pkg::msal_decode_t decode_code(msal_pkg::msal_site_code_t c,
                                                       logic cap);
    msal_pkg::msal_decode_t d;
    logic [2:0]             lm1;
    logic [5:0]             si;
    d   = '0;
    lm1 = c.label - 3'h1;
    si  = {lm1[1:0], c.field};
    if (!cap || c.label == msal_pkg::LABEL_II) begin
      // without SI support the label is ignored and the field is an II
      d.ok          = 1'b1;
      d.idx         = {3'h0, c.field};
      d.parity_code = {msal_pkg::LABEL_II, c.field};
    end else if (c.label <= msal_pkg::LABEL_SI_MAX) begin
      d.ok          = (si != 6'h00);
      d.is_si       = 1'b1;
      d.idx         = msal_pkg::SI_BASE_IDX + {1'b0, si};
      d.parity_code = {c.label, c.field};
    end else begin
      // undefined label: no timer, discarded
      d.parity_code = {c.label, c.field};
    end
    return d;
  endfunction

  msal_pkg::msal_decode_t ac_dec;
  msal_pkg::msal_decode_t lk_dec;
  msal_pkg::msal_entry_t  rd_a;
  msal_pkg::msal_entry_t  rd_b;
  msal_pkg::msal_entry_t  wr_data;
  logic [msal_pkg::IDX_W-1:0] wr_addr;
  logic                   wr_en;
  logic                   lock_wr;
  logic                   clear_wr;
  logic                   entry_live;
  logic                   sweep_live;
  logic                   locked;
  logic [31:0]            age_a;
  logic [31:0]            age_b;

  // pipeline and sweep state
  logic [31:0]                now_q;
  logic                       s1_valid_q;
  msal_pkg::msal_decode_t     s1_dec_q;
  logic                       s1_fwd_q;
  logic [msal_pkg::IDX_W-1:0] sweep_idx_q;
  logic [msal_pkg::IDX_W-1:0] sweep_chk_q;
  logic                       sweep_chk_valid_q;
  logic                       sweep_hit_q;

  assign ac_dec = decode_code(allcall_code_in, si_capable_in);
  assign lk_dec = decode_code(lock_code_in, si_capable_in);

  // free-running time base; the sweep clears entries long before it wraps
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      now_q <= 32'h0000_0000;
    end else begin
      now_q <= now_q + 32'h0000_0001;
    end
  end

  // age is one more than the cycles since the command edge, read a cycle late
  assign age_a      = now_q - rd_a.stamp;
  assign age_b      = now_q - rd_b.stamp;
  assign entry_live = rd_a.valid && (age_a < LOCKOUT_CYCLES);
  assign sweep_live = rd_b.valid && (age_b < LOCKOUT_CYCLES);

  // lockout command has priority on the single write port
  assign lock_wr  = lock_cmd_valid_in && lk_dec.ok;
  assign clear_wr = !lock_wr && sweep_chk_valid_q && rd_b.valid && !sweep_live
                    && !sweep_hit_q;
  assign wr_en    = lock_wr || clear_wr;

  // address and data follow whichever request holds the write port
  always_comb begin
    wr_addr = sweep_chk_q;
    wr_data = '0;
    if (lock_wr) begin
      wr_addr = lk_dec.idx;
      wr_data = {1'b1, now_q};
    end else if (clear_wr) begin
      wr_data = {1'b0, now_q};
    end
  end

  msal_timer_mem u_mem (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .wr_en_in      (wr_en),
    .wr_addr_in    (wr_addr),
    .wr_data_in    (wr_data),
    .rd_a_addr_in  (ac_dec.idx),
    .rd_a_data_out (rd_a),
    .rd_b_addr_in  (sweep_idx_q),
    .rd_b_data_out (rd_b)
  );

  // stage 1: memory read in flight
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_valid_q <= 1'b0;
    end else begin
      s1_valid_q <= allcall_valid_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_dec_q <= '0;
    end else begin
      s1_dec_q <= ac_dec;
    end
  end

  // the memory hands back the old entry when a lockout to the same code is
  // written in the read cycle, so that hit is remembered here
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_fwd_q <= 1'b0;
    end else begin
      s1_fwd_q <= lock_wr && ac_dec.ok && (lk_dec.idx == ac_dec.idx);
    end
  end

  assign locked = s1_fwd_q || entry_live
                  || (lock_wr && lk_dec.idx == s1_dec_q.idx);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reply_valid_out <= 1'b0;
    end else begin
      reply_valid_out <= s1_valid_q;
    end
  end

  // fields are meaningful only with the pulse and hold until the next one
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reply_out <= '0;
    end else if (s1_valid_q) begin
      reply_out.answer      <= s1_dec_q.ok && !locked;
      reply_out.is_si       <= s1_dec_q.is_si;
      reply_out.parity_code <= s1_dec_q.parity_code;
    end
  end

  // background sweep retires expired entries so the wrapping stamp never revives one
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sweep_idx_q <= 7'h00;
    end else if (sweep_idx_q == 7'(msal_pkg::TIMER_COUNT - 1)) begin
      sweep_idx_q <= 7'h00;
    end else begin
      sweep_idx_q <= sweep_idx_q + 7'h01;
    end
  end

  // index and qualifier of the entry whose read data arrive this cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sweep_chk_q       <= 7'h00;
      sweep_chk_valid_q <= 1'b0;
    end else begin
      sweep_chk_q       <= sweep_idx_q;
      sweep_chk_valid_q <= 1'b1;
    end
  end

  // a lockout written while this entry was read makes the read stale
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sweep_hit_q <= 1'b0;
    end else begin
      sweep_hit_q <= lock_wr && (lk_dec.idx == sweep_idx_q);
    end
  end

endmodule // msal_top

// >>> bench/msal_chk.sv
// Purpose: port assertions for msal_top
// Assumes: one clock, srst_in synchronous active high
// Notes:   each decision is judged two edges after its all-call
`timescale 1ns/1ns
module msal_chk (
  input wire logic                      clk_in,
  input wire logic                      srst_in,
  input wire logic                      si_capable_in,
  input wire logic                      allcall_valid_in,
  input wire msal_pkg::msal_site_code_t allcall_code_in,
  input wire logic                      lock_cmd_valid_in,
  input wire msal_pkg::msal_site_code_t lock_code_in,
  input wire logic                      reply_valid_out,
  input wire msal_pkg::msal_reply_t     reply_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  sequence s_reply;
    ##2 reply_valid_out;
  endsequence
  sequence s_refuse;
    ##2 reply_valid_out && !reply_out.answer;
  endsequence
  property p_lat;
    allcall_valid_in |-> s_reply;
  endproperty
  property p_once;
    reply_valid_out |-> $past(allcall_valid_in, 2);
  endproperty
  property p_par;
    allcall_valid_in && si_capable_in |-> ##2 reply_out.parity_code == $past(allcall_code_in, 2);
  endproperty
  property p_old;
    allcall_valid_in && !si_capable_in |->
      ##2 !reply_out.is_si && reply_out.parity_code == {3'h0, $past(allcall_code_in.field, 2)};
  endproperty
  property p_si;
    allcall_valid_in && si_capable_in && allcall_code_in.label inside {[3'h1:3'h4]} |->
      ##2 reply_out.is_si;
  endproperty
  property p_si0;
    allcall_valid_in && si_capable_in && allcall_code_in == 7'h10 |-> s_refuse;
  endproperty
  property p_lbl;
    allcall_valid_in && si_capable_in && allcall_code_in.label > 3'h4 |-> s_refuse;
  endproperty
  property p_lock;
    allcall_valid_in && lock_cmd_valid_in && lock_code_in == allcall_code_in &&
      allcall_code_in.label == 3'h0 |-> s_refuse;
  endproperty
  a_lat:  assert property (p_lat)  else $error("no decision two cycles after all-call");
  a_once: assert property (p_once) else $error("decision without an all-call");
  a_par:  assert property (p_par)  else $error("parity code differs from site code");
  a_old:  assert property (p_old)  else $error("legacy parity code wrong");
  a_si:   assert property (p_si)   else $error("nonzero label not taken as surveillance");
  a_si0:  assert property (p_si0)  else $error("surveillance zero answered");
  a_lbl:  assert property (p_lbl)  else $error("undefined label answered");
  a_lock: assert property (p_lock) else $error("answered while lock lands");
endmodule // msal_chk
bind msal_top msal_chk u_msal_chk (.clk_in(clk_in), .srst_in(srst_in),
  .si_capable_in(si_capable_in), .allcall_valid_in(allcall_valid_in),
  .allcall_code_in(allcall_code_in), .lock_cmd_valid_in(lock_cmd_valid_in),
  .lock_code_in(lock_code_in), .reply_valid_out(reply_valid_out), .reply_out(reply_out));

// >>> bench/msal_ground.sv
// Purpose: ground interrogator model issuing all-calls and lockout commands
// Assumes: strobes move 1 ns after the rising edge
// Notes:   idle code lines invert so a stale code never looks fresh
`timescale 1ns/1ns
module msal_ground (
  input  wire logic                 clk_in,
  input  wire logic                 rv_in,
  input  wire msal_pkg::msal_reply_t rep_in,
  output logic                      ac_out,
  output msal_pkg::msal_site_code_t ac_code_out,
  output logic                      lk_out,
  output msal_pkg::msal_site_code_t lk_code_out
);
  int   acquired;
  logic legacy;
  logic accept_match;
  logic intermittent;
  initial begin
    acquired = 0;
    legacy = 1'b0;
    accept_match = 1'b1;
    intermittent = 1'b1;
    ac_out = 1'b0;
    lk_out = 1'b0;
    ac_code_out = 7'h00;
    lk_code_out = 7'h00;
  end
  // one slot per call; idle slots between calls model a slow scan
  task automatic slot(input logic ac, input logic [6:0] ac_c, input logic lk,
                      input logic [6:0] lk_c);
    @(posedge clk_in);
    #1;
    ac_out = ac;
    ac_code_out = ac ? ac_c : ~ac_code_out;
    lk_out = lk;
    lk_code_out = lk ? lk_c : ~lk_code_out;
  endtask
  // one scan for one own code: all-call, read the reply, file it, then lock out
  task automatic scan(input logic [6:0] own, input int n);
    logic [6:0] match;
    logic       hit;
    match = {3'h0, own[3:0]};
    hit = 1'b0;
    slot(1'b1, own, 1'b0, 7'h00);
    slot(1'b0, 7'h00, 1'b0, 7'h00);
    slot(1'b0, 7'h00, 1'b0, 7'h00);
    @(negedge clk_in);
    if (rv_in && rep_in.answer && rep_in.parity_code == own) hit = 1'b1;
    if (rv_in && rep_in.answer && accept_match && rep_in.parity_code == match &&
        match != own) begin
      hit = 1'b1;
      legacy = 1'b1;
    end
    // the file holds a count only: the reply carries no address in this block
    if (hit) acquired++;
    // legacy targets are locked on the matching code; intermittent skips odd scans
    if (hit && !(intermittent && n[0])) begin
      slot(1'b0, 7'h00, 1'b1, legacy ? match : own);
    end else begin
      slot(1'b0, 7'h00, 1'b0, 7'h00);
    end
  endtask
endmodule // msal_ground

// >>> bench/tb_msal_top.sv
// Purpose: self-checking bench for msal_top against a lockout model
// Assumes: short lockout parameter; ground model drives the strobes
// Notes:   expectations settle at the reply edge so a late lockout is seen
`timescale 1ns/1ns
module tb_msal_top;
  localparam int L = 40;
  localparam logic [6:0] PROBE [5] = '{7'h21, 7'h01, 7'h11, 7'h31, 7'h00};
  typedef struct {int e; int i; logic [6:0] c; logic lkd;} msal_pend_t;
  logic clk_in, srst_in, cap, ac, lk, rv;
  logic [15:0] lfsr;
  msal_pkg::msal_site_code_t acc, lkc;
  msal_pkg::msal_reply_t rep;
  int bad_count, checks, cyc, le[79];
  msal_pend_t pq[$], p;
  msal_ground u_msal_ground (.clk_in(clk_in), .rv_in(rv), .rep_in(rep), .ac_out(ac),
    .ac_code_out(acc), .lk_out(lk), .lk_code_out(lkc));
  msal_top #(.LOCKOUT_CYCLES(32'(L))) u_msal_top (.clk_in(clk_in), .srst_in(srst_in),
    .si_capable_in(cap), .allcall_valid_in(ac), .allcall_code_in(acc),
    .lock_cmd_valid_in(lk), .lock_code_in(lkc), .reply_valid_out(rv), .reply_out(rep));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  function automatic int idx(logic [6:0] c);
    if (!cap || c[6:4] == 3'h0) return int'(c[3:0]);
    if (c[6:4] > 3'h4 || c == 7'h10) return -1;
    return 15 + (int'(c[6:4]) - 1) * 16 + int'(c[3:0]);
  endfunction
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (srst_in) begin
      foreach (le[k]) le[k] = -1000;
      pq.delete();
    end else begin
      if (lk && idx(lkc) >= 0) begin
        le[idx(lkc)] = cyc;
        foreach (pq[k]) if (pq[k].i == idx(lkc) && pq[k].e == cyc - 1) pq[k].lkd = 1'b1;
      end
      if (ac) begin
        p.e = cyc;
        p.i = idx(acc);
        p.c = acc;
        // age seen by the design is one more than the edges since the command
        p.lkd = p.i >= 0 && cyc - le[p.i >= 0 ? p.i : 0] < L - 1;
        pq.push_back(p);
      end
    end
  end
  always @(negedge clk_in) if (!srst_in) begin
    // the pulse stands between the first and second edge after the all-call
    if (pq.size() > 0 && pq[0].e == cyc - 1) begin
      p = pq.pop_front();
      chk("reply", {rv, rep}, {1'b1, p.i >= 0 && !p.lkd, cap && p.c[6:4] != 3'h0 &&
        p.c[6:4] <= 3'h4, cap ? p.c : {3'h0, p.c[3:0]}});
    end else chk("idle", 10'(rv), 10'h000);
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    final_report();
  end
  initial begin
    srst_in = 1'b1;
    cap = 1'b1;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    lfsr = 16'hc5c2;
    for (int ph = 0; ph < 2; ph++) begin
      @(posedge clk_in);
      #1;
      srst_in = 1'b1;
      cap = (ph == 0);
      repeat (12) @(posedge clk_in);
      #1;
      srst_in = 1'b0;
      for (int c = 0; c < 128; c++) u_msal_ground.slot(1'b1, 7'(c), 1'b0, 7'h00);
      // lock and probe on the same edge, then step across expiry
      for (int k = 0; k < L + 4; k++) u_msal_ground.slot(1'b1, 7'h03, k == 0, 7'h03);
      u_msal_ground.slot(1'b0, 7'h00, 1'b1, 7'h21);
      u_msal_ground.slot(1'b0, 7'h00, 1'b1, 7'h00);
      foreach (PROBE[k]) u_msal_ground.slot(1'b1, PROBE[k], 1'b0, 7'h00);
      repeat (300) begin
        lfsr = lfsr_step(lfsr);
        u_msal_ground.slot(lfsr[0], lfsr[7:1] & 7'h13, lfsr[8] & lfsr[9], lfsr[14:8] & 7'h13);
      end
      // fresh code that no earlier step touched; scan 1 files but skips the lockout, scan 3 is refused under the lock
      u_msal_ground.legacy = 1'b0;
      u_msal_ground.acquired = 0;
      for (int n = 1; n < 4; n++) u_msal_ground.scan(7'h2e, n);
      chk("filed", 10'(u_msal_ground.acquired), 10'h002);
      chk("legacy", 10'(u_msal_ground.legacy), 10'(!cap));
      repeat (4) u_msal_ground.slot(1'b0, 7'h00, 1'b0, 7'h00);
      chk("drain", 10'(pq.size()), 10'h000);
    end
    final_report();
  end
endmodule // tb_msal_top
